// *** inc/pem_map.svh ***
`ifndef PEM_MAP_SVH
`define PEM_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PEM_CTRL_OFS 12'h000
`define PEM_STAT_OFS 12'h004

// ----------------------------------------
// control register fields
// ----------------------------------------
`define PEM_CTRL_ACTIVATE 0
`define PEM_CTRL_START_AUTO 1
`define PEM_CTRL_RUN_AUTO 2
`define PEM_CTRL_RESET_VAL 3'h0

// ----------------------------------------
// status register fields
// ----------------------------------------
`define PEM_STAT_CODE_LSB 0
`define PEM_STAT_READY 16
`define PEM_STAT_ENABLE 17
`define PEM_STAT_ERROR 18
`define PEM_STAT_REQ 19
`define PEM_STAT_RST 20

// ----------------------------------------
// status code words
// ----------------------------------------
`define PEM_CODE_IDLE 16'h0000
`define PEM_CODE_ENABLED 16'h8000
`define PEM_CODE_INIT 16'h8001
`define PEM_CODE_WREQ1 16'h8002
`define PEM_CODE_WRST1 16'h8003
`define PEM_CODE_WREQ2 16'h8004
`define PEM_CODE_WRST2 16'h8005
`define PEM_CODE_ERR1 16'hc001
`define PEM_CODE_ERR2 16'hc002

`endif

// *** inc/pem_pkg.sv ***
package pem_pkg;

  // ----------------------------------------
  // monitor states, gray from idle through the second reset wait; the step from that wait back to enabled changes two bits
  // ----------------------------------------
  typedef enum logic [3:0] {
    PEM_IDLE    = 4'h0,
    PEM_INIT    = 4'h1,
    PEM_WREQ1   = 4'h3,
    PEM_WRST1   = 4'h2,
    PEM_ENABLED = 4'h6,
    PEM_WREQ2   = 4'h7,
    PEM_WRST2   = 4'h5,
    PEM_ERR1    = 4'h4,
    PEM_ERR2    = 4'hc
  } pem_state_t;

endpackage : pem_pkg

// *** inc/pem_cfg_if.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// settings down to the core, state back up
// ----------------------------------------
interface pem_cfg_if;
  logic activate; // block active
  logic start_auto; // startup auto-confirm
  logic run_auto; // run-time auto-confirm
  logic [15:0] code; // status code word
  logic ready; // ready flag
  logic enable; // safety enable
  logic error; // error flag
  logic req; // synchronised request level
  logic rst; // synchronised operator reset

  modport regs (output activate, output start_auto, output run_auto,
                input code, input ready, input enable, input error, input req, input rst);
  modport core (input activate, input start_auto, input run_auto,
                output code, output ready, output enable, output error, output req, output rst);
endinterface : pem_cfg_if

// *** rtl/pem_sync.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// two-stage synchroniser for pin levels
// ----------------------------------------
module pem_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta; // first stage, read only by q
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // next values
  always_comb
  begin
    next_meta = d;
    next_q = meta;
  end

  // registers; reset low means request asserted, the safe side
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= next_meta;
      q <= next_q;
    end
  end

endmodule : pem_sync

// *** rtl/pem_apb_regs.sv ***
`timescale 1ns/1ps
`include "pem_map.svh"

// ----------------------------------------
// apb slave: control and status words
// ----------------------------------------
module pem_apb_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  pem_cfg_if.regs cfg
);
  import pem_pkg::*;

  logic [2:0] ctrl; // activate, start auto, run auto
  logic [2:0] next_ctrl;
  logic [31:0] next_prdata;
  logic hit; // mapped address

  // decode, always zero wait
  assign hit = (paddr == `PEM_CTRL_OFS) || (paddr == `PEM_STAT_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  assign cfg.activate = ctrl[`PEM_CTRL_ACTIVATE];
  assign cfg.start_auto = ctrl[`PEM_CTRL_START_AUTO];
  assign cfg.run_auto = ctrl[`PEM_CTRL_RUN_AUTO];

  // write on the access edge, read data captured in setup
  always_comb
  begin
    next_ctrl = ctrl;
    next_prdata = prdata;
    if (psel && penable && pwrite && pstrb[0] && paddr == `PEM_CTRL_OFS)
      next_ctrl = pwdata[2:0];
    if (psel && !penable)
    begin
      next_prdata = 32'h0;
      if (paddr == `PEM_CTRL_OFS)
        next_prdata[2:0] = ctrl;
      else if (paddr == `PEM_STAT_OFS)
      begin
        next_prdata[15:0] = cfg.code;
        next_prdata[`PEM_STAT_READY] = cfg.ready;
        next_prdata[`PEM_STAT_ENABLE] = cfg.enable;
        next_prdata[`PEM_STAT_ERROR] = cfg.error;
        next_prdata[`PEM_STAT_REQ] = cfg.req;
        next_prdata[`PEM_STAT_RST] = cfg.rst;
      end
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `PEM_CTRL_RESET_VAL;
      prdata <= 32'h0;
    end
    else
    begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
    end
  end

endmodule : pem_apb_regs

// *** rtl/pem_top.sv ***
`timescale 1ns/1ps
`include "pem_map.svh"

// ----------------------------------------
// protective equipment monitor
// ----------------------------------------
// Functional notes
// R1: request low drops enable immediately
// R2: enable only with request and confirmation
// R3: run-time auto confirms after request clears
// R4: otherwise need reset rising edge
// R5: startup auto confirms first activation
// R6: otherwise first enable needs reset edge
// R7: deactivate goes idle, highest priority
// R8: reset already high on entry: error
// R9: leave error only after reset low
// R10: error codes c001 and c002
// R11: idle reports 0000, all flags low
// R12: init reports 8001, ready high
// R13: first request wait reports 8002
// R14: first reset wait reports 8003
// R15: 16-bit status code, defaults zero
// R16: enable low whenever response pending
// R17: second request wait reports 8004
// R18: second reset wait reports 8005
// R19: enabled reports 8000, enable high
// R20: reset edge from current versus previous
// R21: confirm enters enabled; drop enters 8004
module pem_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensor and operator pins
  input wire logic safety_request_in,
  input wire logic operator_reset_in,
  // monitor outputs
  output logic safety_enable_out,
  output logic ready_out,
  output logic error_out,
  output logic [15:0] status_code_word
);
  import pem_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  pem_cfg_if cfg (); // link between register file and core
  logic [1:0] pin_sync; // synchronised request, reset
  logic req; // high: no safety request
  logic rst_now; // operator reset this cycle
  logic rst_prev; // operator reset last cycle
  logic rst_rise; // rising edge of operator reset
  pem_state_t state; // current monitor state
  pem_state_t next_state;
  logic started; // first activation already confirmed
  logic next_started;
  logic next_rst_prev;
  logic ready_q; // registered ready
  logic error_q; // registered error
  logic en_q; // registered enable state
  logic [15:0] code_q; // registered code
  logic next_ready;
  logic next_error;
  logic next_en;
  logic [15:0] next_code;

  // ----------------------------------------
  // code for a state
  // ----------------------------------------
  // decode used only for the registered code; the flags compare next_state directly
  function automatic logic [15:0] pem_code(input pem_state_t s);
    logic [15:0] c;
    c = `PEM_CODE_IDLE; // [R15]
    unique case (s)
      PEM_IDLE: c = `PEM_CODE_IDLE; // [R11]
      PEM_INIT: c = `PEM_CODE_INIT; // [R12]
      PEM_WREQ1: c = `PEM_CODE_WREQ1; // [R13]
      PEM_WRST1: c = `PEM_CODE_WRST1; // [R14]
      PEM_ENABLED: c = `PEM_CODE_ENABLED; // [R19]
      PEM_WREQ2: c = `PEM_CODE_WREQ2; // [R17]
      PEM_WRST2: c = `PEM_CODE_WRST2; // [R18]
      PEM_ERR1: c = `PEM_CODE_ERR1; // [R10]
      PEM_ERR2: c = `PEM_CODE_ERR2; // [R10]
      default: c = `PEM_CODE_IDLE;
    endcase
    return c;
  endfunction : pem_code

  // ----------------------------------------
  // entry to a reset wait, error if reset already high
  // ----------------------------------------
  // a button already pressed on entry was never seen as an edge, so it is
  // treated as a fault rather than as a confirmation
  function automatic pem_state_t pem_wait_entry(input pem_state_t wait_s, input pem_state_t err_s,
                                                input logic rst_level);
    pem_state_t s;
    s = wait_s;
    if (rst_level)
      s = err_s; // [R8]
    return s;
  endfunction : pem_wait_entry

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  pem_sync #(
    .WIDTH(2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({operator_reset_in, safety_request_in}),
    .q(pin_sync)
  );

  // both pins cross together; a request and a reset that change in one
  // cycle also reach the state machine in one cycle
  assign req = pin_sync[0];
  assign rst_now = pin_sync[1];
  // edge from this cycle against the last one; the previous level resets
  // low, so a button held through startup gives one edge in idle or init,
  // where nothing reads it, and an error on entry to a reset wait
  assign rst_rise = rst_now && !rst_prev; // [R20]

  // ----------------------------------------
  // register file
  // ----------------------------------------
  pem_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg)
  );

  // ----------------------------------------
  // monitor state machine, next state
  // ----------------------------------------
  // only the reset wait states read the edge; all others look at levels,
  // so a held button never confirms twice
  always_comb
  begin
    next_state = state;
    next_started = started;
    next_rst_prev = rst_now;
    unique case (state)
      // idle until activated
      PEM_IDLE:
      begin
        next_state = PEM_INIT;
      end
      // one cycle, then on to the first request wait, where startup confirm is decided
      PEM_INIT:
      begin
        next_state = PEM_WREQ1; // [R12]
      end
      // wait for the request input to clear
      PEM_WREQ1:
      begin
        if (req)
        begin
          // only the first clearance after startup may confirm itself
          if (cfg.start_auto && !started)
          begin
            next_state = PEM_ENABLED; // [R5]
            next_started = 1'b1;
          end
          else
            next_state = pem_wait_entry(PEM_WRST1, PEM_ERR1, rst_now); // [R6]
        end
      end
      // first confirmation by operator edge
      PEM_WRST1:
      begin
        if (!req)
          next_state = PEM_WREQ1; // [R16]
        else if (rst_rise)
        begin
          next_state = PEM_ENABLED; // [R14] [R21]
          next_started = 1'b1;
        end
      end
      // running; a request drops to the second wait
      // the pin itself already fell through the live gate below
      PEM_ENABLED:
      begin
        if (!req)
          next_state = PEM_WREQ2; // [R21]
      end
      // wait for the request to clear again
      PEM_WREQ2:
      begin
        if (req)
        begin
          if (cfg.run_auto)
            next_state = PEM_ENABLED; // [R3]
          else
            next_state = pem_wait_entry(PEM_WRST2, PEM_ERR2, rst_now); // [R4]
        end
      end
      // second confirmation, auto or by edge
      PEM_WRST2:
      begin
        if (!req)
          next_state = PEM_WREQ2; // [R16]
        // run-time auto set while waiting here also proceeds
        else if (cfg.run_auto || rst_rise)
          next_state = PEM_ENABLED; // [R18]
      end
      // reset error, released only with reset low
      // a button stuck high keeps the error, which is the safe reading
      PEM_ERR1:
      begin
        if (!rst_now)
          next_state = PEM_WREQ1; // [R9]
      end
      PEM_ERR2:
      begin
        if (!rst_now)
          next_state = PEM_WREQ2; // [R9]
      end
      default:
      begin
        next_state = PEM_IDLE; // illegal code falls back safe
      end
    endcase
    // deactivation overrides every other move
    if (!cfg.activate)
      next_state = PEM_IDLE; // [R7]
  end

  // ----------------------------------------
  // outputs follow the next state, so they line up with it
  // ----------------------------------------
  // keeps the flags in step with code_q; the cost is a longer path
  // from the synchronised pins through the case above
  always_comb
  begin
    next_code = pem_code(next_state); // [R15]
    next_ready = (next_state != PEM_IDLE); // [R11] [R12]
    next_error = (next_state == PEM_ERR1) || (next_state == PEM_ERR2); // [R8]
    next_en = (next_state == PEM_ENABLED); // [R2] [R19]
  end

  // ----------------------------------------
  // state and output registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= PEM_IDLE; // [R11]
      // first-start memory survives deactivation, cleared only here
      started <= 1'b0;
      rst_prev <= 1'b0;
      ready_q <= 1'b0;
      error_q <= 1'b0;
      en_q <= 1'b0;
      code_q <= `PEM_CODE_IDLE;
    end
    else
    begin
      state <= next_state;
      started <= next_started;
      rst_prev <= next_rst_prev;
      ready_q <= next_ready;
      error_q <= next_error;
      en_q <= next_en;
      code_q <= next_code;
    end
  end

  // ----------------------------------------
  // pins and status back to software
  // ----------------------------------------
  // the live request gates the enable so a drop is never a cycle late
  assign safety_enable_out = en_q && req; // [R1] [R16]
  assign ready_out = ready_q;
  assign error_out = error_q;
  assign status_code_word = code_q;

  // status word reads the gated enable, the same level as the pin
  assign cfg.code = code_q;
  assign cfg.ready = ready_q;
  assign cfg.enable = safety_enable_out;
  assign cfg.error = error_q;
  // raw synchronised levels, for checking the wiring from software
  assign cfg.req = req;
  assign cfg.rst = rst_now;

endmodule : pem_top

// *** bench/pem_sensor.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// light curtain and operator push-button
// ----------------------------------------
module pem_sensor (
  // clock
  input wire logic pclk,
  // levels asked for by the bench
  input wire logic want_clear,
  input wire logic want_reset,
  // pins toward the monitor
  output logic safety_request_in = 1'b0,
  output logic operator_reset_in = 1'b0
);
  // contacts settle just after an edge, never mid-cycle
  always_ff @(posedge pclk)
  begin
    safety_request_in <= want_clear;
    operator_reset_in <= want_reset;
  end
endmodule : pem_sensor

// *** bench/pem_top_properties.sv ***
`timescale 1ns/1ps
`include "pem_map.svh"

// ----------------------------------------
// port-level checker for the monitor
// ----------------------------------------
module pem_top_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  // pins and outputs
  input wire logic safety_request_in,
  input wire logic operator_reset_in,
  input wire logic safety_enable_out,
  input wire logic ready_out,
  input wire logic error_out,
  input wire logic [15:0] status_code_word
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // two sync stages, so the drop lands by the third edge
  a_drop_fast: assert property ($fell(safety_request_in) |-> ##2 !safety_enable_out)
    else $error("enable still high after request drop");
  a_enable_code: assert property (safety_enable_out |->
    status_code_word == `PEM_CODE_ENABLED && ready_out && !error_out)
    else $error("enable high outside enabled state");
  a_enable_entry: assert property ($rose(safety_enable_out) |->
    $past(status_code_word) inside {`PEM_CODE_WREQ1, `PEM_CODE_WRST1, `PEM_CODE_WREQ2, `PEM_CODE_WRST2})
    else $error("enable rose from a wrong state");
  a_idle_flags: assert property (status_code_word == `PEM_CODE_IDLE |->
    !ready_out && !error_out && !safety_enable_out)
    else $error("idle flags wrong");
  a_init_once: assert property (status_code_word == `PEM_CODE_INIT |=>
    status_code_word inside {`PEM_CODE_WREQ1, `PEM_CODE_IDLE})
    else $error("init did not move on");
  a_error_entry: assert property ($rose(error_out) |->
    (status_code_word == `PEM_CODE_ERR1 && $past(status_code_word) == `PEM_CODE_WREQ1) ||
    (status_code_word == `PEM_CODE_ERR2 && $past(status_code_word) == `PEM_CODE_WREQ2))
    else $error("error raised with wrong code");
  a_error_hold: assert property (error_out && operator_reset_in && $past(operator_reset_in, 2) |=>
    error_out || status_code_word == `PEM_CODE_IDLE)
    else $error("error left while reset high");
  a_error_flags: assert property (error_out |-> ready_out && !safety_enable_out)
    else $error("error flags wrong");
  a_unmapped: assert property (psel && penable && !(paddr inside {`PEM_CTRL_OFS, `PEM_STAT_OFS}) |-> pslverr)
    else $error("unmapped access not refused");
endmodule : pem_top_checker

bind pem_top pem_top_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pslverr(pslverr), .safety_request_in(safety_request_in), .operator_reset_in(operator_reset_in),
  .safety_enable_out(safety_enable_out), .ready_out(ready_out), .error_out(error_out),
  .status_code_word(status_code_word));

// *** bench/pem_top_test.sv ***
`timescale 1ns/1ps
`include "pem_map.svh"

// ----------------------------------------
// self-checking bench
// ----------------------------------------
module pem_top_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, serr, req_pin, rst_pin, en_out, rdy_out, err_out;
  logic want_clear = 1'b0;
  logic want_reset = 1'b0;
  logic [15:0] code;
  logic auto_r; // random run-time auto choice
  int n_mismatch = 0;
  int n_tests = 0;

  always #2 pclk = ~pclk;

  pem_sensor i_sensor (.pclk(pclk), .want_clear(want_clear), .want_reset(want_reset),
    .safety_request_in(req_pin), .operator_reset_in(rst_pin));
  pem_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .safety_request_in(req_pin), .operator_reset_in(rst_pin), .safety_enable_out(en_out),
    .ready_out(rdy_out), .error_out(err_out), .status_code_word(code));

  // flags implied by a status code
  function automatic logic [31:0] exp_word(input logic [15:0] c);
    exp_word = {13'h0, c[15:14] == 2'b11, c == `PEM_CODE_ENABLED, c != `PEM_CODE_IDLE, c};
  endfunction : exp_word

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
      if (i == 20)
      begin
        n_mismatch++;
        end_sim();
      end
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // control word with random reserved bits
  task automatic ctrl(input logic [2:0] v);
    apb(1'b1, `PEM_CTRL_OFS, {29'($urandom), v});
  endtask : ctrl

  // move the sensor pins after a random pause
  task automatic pins(input logic c, input logic r);
    repeat ($urandom_range(1, 4)) @(posedge pclk);
    want_clear <= c;
    want_reset <= r;
  endtask : pins

  task automatic pulse();
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
  endtask : pulse

  // bounded wait for a code, then ports, and the status word when rd_stat is set
  task automatic look(input logic [15:0] c, input logic rd_stat);
    for (int i = 0; i <= 40; i++)
    begin
      @(negedge pclk);
      if (code === c)
        break;
      if (i == 40)
      begin
        n_mismatch++;
        end_sim();
      end
    end
    check({13'h0, err_out, en_out, rdy_out, code}, exp_word(c));
    if (rd_stat)
    begin
      apb(1'b0, `PEM_STAT_OFS, 32'h0);
      check(rd & 32'hfffff, exp_word(c) | {12'h0, want_clear, 19'h0});
    end
  endtask : look

  initial
  begin
    void'($urandom(32'h35bdba74));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `PEM_CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check({31'h0, serr}, 32'h1);
    look(`PEM_CODE_IDLE, 1'b1);
    $display("test reset done");
    ctrl(3'b001);
    look(`PEM_CODE_INIT, 1'b0);
    look(`PEM_CODE_WREQ1, 1'b1);
    pins(1'b1, 1'b0);
    look(`PEM_CODE_WRST1, 1'b1);
    pulse();
    look(`PEM_CODE_ENABLED, 1'b1);
    pins(1'b0, 1'b0);
    look(`PEM_CODE_WREQ2, 1'b1);
    pins(1'b1, 1'b0);
    look(`PEM_CODE_WRST2, 1'b1);
    pulse();
    look(`PEM_CODE_ENABLED, 1'b0);
    $display("test manual confirm done");
    ctrl(3'b000);
    look(`PEM_CODE_IDLE, 1'b0);
    pins(1'b0, 1'b1);
    ctrl(3'b001);
    look(`PEM_CODE_WREQ1, 1'b0);
    pins(1'b1, 1'b1);
    look(`PEM_CODE_ERR1, 1'b1);
    repeat (6) @(posedge pclk);
    look(`PEM_CODE_ERR1, 1'b0);
    pins(1'b1, 1'b0);
    look(`PEM_CODE_WRST1, 1'b0);
    pulse();
    look(`PEM_CODE_ENABLED, 1'b0);
    ctrl(3'b101);
    pins(1'b0, 1'b0);
    look(`PEM_CODE_WREQ2, 1'b0);
    pins(1'b1, 1'b0);
    look(`PEM_CODE_ENABLED, 1'b0);
    ctrl(3'b001);
    pins(1'b0, 1'b1);
    look(`PEM_CODE_WREQ2, 1'b0);
    pins(1'b1, 1'b1);
    look(`PEM_CODE_ERR2, 1'b1);
    pins(1'b0, 1'b0);
    look(`PEM_CODE_WREQ2, 1'b0);
    $display("test errors done");
    // random restarts, with and without run-time auto
    for (int k = 0; k < 8; k++)
    begin
      auto_r = 1'($urandom);
      ctrl({auto_r, 2'b01});
      pins(1'b1, 1'b0);
      if (auto_r)
        look(`PEM_CODE_ENABLED, 1'b0);
      else
      begin
        look(`PEM_CODE_WRST2, 1'b0);
        if (k[0])
        begin
          pins(1'b0, 1'b0);
          look(`PEM_CODE_WREQ2, 1'b0);
          pins(1'b1, 1'b0);
          look(`PEM_CODE_WRST2, 1'b0);
        end
        pulse();
        look(`PEM_CODE_ENABLED, 1'b0);
      end
      pins(1'b0, 1'b0);
      look(`PEM_CODE_WREQ2, 1'b0);
    end
    $display("test random restarts done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ctrl(3'b011);
    look(`PEM_CODE_WREQ1, 1'b0);
    pins(1'b1, 1'b0);
    look(`PEM_CODE_ENABLED, 1'b1);
    ctrl(3'b010);
    look(`PEM_CODE_IDLE, 1'b0);
    $display("test startup confirm done");
    end_sim();
  end
endmodule : pem_top_test
